// file: verif/key_matrix_model.sv
// Behavioural key switch matrix with row pull-ups
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model (
   input wire logic [3:0] col_n,
   input wire logic [19:0] keys,
   output logic [4:0] rows
);
   // Each switch isolated, no sneak paths between rows; an open row floats up to the pull-up
   always_comb begin
      for (int r = 0; r < 5; r++) begin
         rows[r] = ~|(keys[r*4 +: 4] & ~col_n);
      end
   end
endmodule
`default_nettype wire

// file: verif/test_key_matrix_scan_encoder.sv
// Self-checking bench for the key matrix scan encoder
`timescale 1ns/1ps
`default_nettype none
`include "key_scan_regs.svh"
module test_key_matrix_scan_encoder;
   logic aclk = 1'h0, aresetn = 1'h0, scan_osc_in = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic debounce_timing_input = 1'h1, output_enable_n = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [19:0] keys = 20'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
   logic [31:0] s_axi_rdata, rd_val;
   logic [3:0] col_n, col_seen;
   logic [4:0] rows, code_out;
   logic code_oe, key_valid;
   int fails = 0, samples_checked = 0, cycles = 0;

   // Short scan step keeps the run brief
   key_matrix_scan_encoder #(.SCAN_DIV_DEFAULT(16'h0008)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .scan_osc_in, .debounce_timing_input,
      .output_enable_n, .row_sense_0(rows[0]), .row_sense_1(rows[1]),
      .row_sense_2(rows[2]), .row_sense_3(rows[3]), .row_sense_4(rows[4]),
      .column_drive_0(col_n[0]), .column_drive_1(col_n[1]),
      .column_drive_2(col_n[2]), .column_drive_3(col_n[3]),
      .code_out, .code_oe, .key_valid
   );
   key_matrix_model model_u (.col_n, .keys, .rows);

   // 100 MHz clock
   always #5 aclk = ~aclk;

   // Hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails++;
         print_verdict();
      end
   end

   task print_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Write: address and data offered together, each dropped once taken
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task rd(input logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd_val = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task press(input logic [19:0] k);
      @(posedge aclk);
      keys <= k;
   endtask

   task wait_kv(input logic v, input int lim);
      int n;
      n = 0;
      while (key_valid !== v && n < lim) begin
         @(posedge aclk);
         n++;
      end
   endtask

   // Reset values, byte lanes, refused offsets and the read-only status word
   task t_regs();
      rd(`REG_CTRL);
      chk(rd_val, 32'h2);
      chk(rd_resp, `RESP_OKAY);
      wr(`REG_SCAN_DIV, 32'hffffff08, 4'h1);
      chk(wr_resp, `RESP_OKAY);
      rd(`REG_SCAN_DIV);
      chk(rd_val, 32'h8);
      rd(`REG_DEBOUNCE);
      chk(rd_val, `DEB_TICKS_RESET);
      wr(4'h1, 32'h3, 4'hf);
      chk(wr_resp, `RESP_SLVERR);
      rd(4'h1);
      chk(rd_resp, `RESP_SLVERR);
      chk(rd_val, 32'h0);
      wr(`REG_STATUS, 32'hffffffff, 4'hf);
      chk(wr_resp, `RESP_OKAY);
      rd(`REG_CTRL);
      chk(rd_val, 32'h2);
      chk(code_oe, 1'h1);
   endtask

   // One column low at a time, one step per scan period
   task t_cols();
      for (int n = 0; n < 40; n++) begin
         @(posedge aclk);
         chk($countones(~col_n), 1);
      end
      col_seen = col_n;
      repeat (32) @(posedge aclk);
      chk(col_n, col_seen);
      repeat (16) @(posedge aclk);
      chk(col_n !== col_seen, 1'h1);
   endtask

   task t_keys();
      for (int i = 0; i < 20; i++) begin
         press(20'h1 << i);
         wait_kv(1'h1, 400);
         chk(code_out, i[4:0]);
         rd(`REG_STATUS);
         chk(rd_val, 32'h201 | (i << 1));
         press(20'h0);
         wait_kv(1'h0, 400);
         chk(key_valid, 1'h0);
         chk(code_out, i[4:0]);
      end
   endtask

   task t_roll();
      press(20'h8);
      wait_kv(1'h1, 400);
      press(20'h208);
      repeat (100) @(posedge aclk);
      chk(code_out, 5'h3);
      press(20'h200);
      wait_kv(1'h0, 400);
      chk(key_valid, 1'h0);
      wait_kv(1'h1, 400);
      chk(code_out, 5'h9);
      press(20'h0);
      wait_kv(1'h0, 400);
   endtask

   // Three corners closed: only the lone key of column 1 may be taken
   task t_phantom();
      press(20'h13);
      wait_kv(1'h1, 400);
      chk(code_out, 5'h1);
      press(20'h0);
      wait_kv(1'h0, 400);
   endtask

   task t_rows4();
      wr(`REG_CTRL, 32'h0, 4'hf);
      press(20'h20000);
      repeat (300) @(posedge aclk);
      chk(key_valid, 1'h0);
      press(20'h0);
      wr(`REG_CTRL, 32'h2, 4'hf);
   endtask

   // Long debounce holds a key back; without the element it is taken at once
   task t_debounce();
      wr(`REG_DEBOUNCE, 32'h40, 4'h1);
      press(20'h40);
      repeat (200) @(posedge aclk);
      chk(key_valid, 1'h0);
      press(20'h0);
      repeat (40) @(posedge aclk);
      debounce_timing_input <= 1'h0;
      press(20'h40);
      wait_kv(1'h1, 80);
      chk(code_out, 5'h6);
      press(20'h0);
      wait_kv(1'h0, 80);
      debounce_timing_input <= 1'h1;
      wr(`REG_DEBOUNCE, 32'h4, 4'h1);
   endtask

   task t_enable();
      press(20'h800);
      output_enable_n <= 1'h1;
      wait_kv(1'h1, 400);
      chk(key_valid, 1'h1);
      chk(code_oe, 1'h0);
      col_seen = col_n;
      output_enable_n <= 1'h0;
      repeat (8) @(posedge aclk);
      chk(code_oe, 1'h1);
      chk(col_n, col_seen);
      press(20'h0);
      wait_kv(1'h0, 400);
   endtask

   // Slow outside scan clock; rising edges 8 cycles apart
   task ext_wait(input logic v);
      for (int n = 0; n < 100 && key_valid !== v; n++) begin
         repeat (4) @(posedge aclk);
         scan_osc_in <= ~scan_osc_in;
      end
      chk(key_valid, v);
   endtask

   task t_ext();
      wr(`REG_CTRL, 32'h3, 4'hf);
      press(20'h20);
      repeat (400) @(posedge aclk);
      chk(key_valid, 1'h0);
      ext_wait(1'h1);
      chk(code_out, 5'h5);
      press(20'h0);
      ext_wait(1'h0);
      wr(`REG_CTRL, 32'h2, 4'hf);
   endtask

   // Reset, then the scenarios in turn
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_cols();
      t_keys();
      t_roll();
      t_phantom();
      t_rows4();
      t_debounce();
      t_enable();
      t_ext();
      print_verdict();
   end
endmodule
`default_nettype wire

// file: verilog/key_matrix_scan_encoder.sv
// Key matrix scan encoder with AXI4-Lite control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "key_scan_regs.svh"

// How it works
// RL1: Scan steps come from an internal divider of the system clock or from rising edges on the external scan clock input.
// RL2: A key is taken only when its row is the sole closed row of the driven column, so phantom keys are never reported.
// RL3: A closure must persist for the set number of scan steps, and with no debounce timing element fitted it is taken at once.
// RL4: Key-valid rises when a debounced closure is accepted.
// RL5: Key-valid falls as soon as the accepted key opens, whatever other key is held.
// RL6: After a release the scan resumes, so a second held key is accepted after one normal debounce interval.
// RL7: The code register keeps the last accepted key on the outputs until a new key is accepted.
// RL8: The code outputs are three-state, driven or released under an output enable so that a bus may be shared.
// RL9: Rows are sensed with pull-ups and four columns are driven, the fifth row being present only in 20-key mode.
// RL10: The code is four times the row plus the column, from 0 to 19, bit 0 being the low bit.
// RL11: An outside scan clock may replace the timing element only if it runs below 10 kHz.
// RL12: The code outputs drive while the active-low enable is low and float otherwise, key-valid always driven.
// RL13: One column is active at a time, advancing each scan step, and the scan halts while a key is debounced or held.
module key_matrix_scan_encoder
   import key_scan_pkg::*;
#(
   parameter logic [15:0] SCAN_DIV_DEFAULT = 16'(`SCAN_PERIOD_NS / `CLK_PERIOD_NS)
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scan_osc_in,
   input wire logic debounce_timing_input,
   input wire logic output_enable_n,
   input wire logic row_sense_0,
   input wire logic row_sense_1,
   input wire logic row_sense_2,
   input wire logic row_sense_3,
   input wire logic row_sense_4,
   output logic column_drive_0,
   output logic column_drive_1,
   output logic column_drive_2,
   output logic column_drive_3,
   output logic [4:0] code_out,
   output logic code_oe,
   output logic key_valid
);

   logic [1:0] ctrl;
   logic [15:0] scan_div;
   logic [7:0] deb_ticks;
   logic [4:0] rows_meta, rows_sync;
   logic [2:0] misc_meta, misc_sync;
   logic osc_prev;
   logic [15:0] div_cnt;
   logic tick;
   scan_state_t state;
   logic [1:0] col;
   key_pos_t cand;
   logic [7:0] deb_cnt;
   logic [4:0] pressed;
   logic single_row;
   logic [2:0] first_row;
   logic cand_closed;
   logic accept;
   logic released;
   logic aw_held, w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Lowest closed row of the driven column
   function automatic logic [2:0] lowest_row(input logic [4:0] p);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 4; i >= 0; i--) begin
         if (p[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // Two-flop synchronisers for the row, scan clock, debounce and enable pins; nothing reads the first stage but the second
   always_ff @(posedge aclk) begin
      rows_meta <= {row_sense_4, row_sense_3, row_sense_2, row_sense_1, row_sense_0};
      rows_sync <= rows_meta;
      misc_meta <= {scan_osc_in, debounce_timing_input, output_enable_n};
      misc_sync <= misc_meta;
      osc_prev <= misc_sync[2];
   end

   // Open row reads high through its pull-up; row 4 ignored in 16-key mode
   assign pressed = ~rows_sync & {ctrl[`CTRL_ROWS5], 4'hf}; // RL9
   assign single_row = (pressed != 5'h00) && ((pressed & (pressed - 5'h01)) == 5'h00); // RL2
   assign first_row = lowest_row(pressed);
   assign cand_closed = (pressed == (5'h01 << cand.row)); // RL2
   assign released = (state == HOLD) && tick && !pressed[cand.row]; // RL5
   // Bypass when no debounce element: a lone closure is taken at its first sighting
   assign accept = tick && ((state == SCAN && single_row && !misc_sync[1]) // RL3
      || (state == DEBOUNCE && cand_closed && deb_cnt >= deb_ticks)); // RL3

   // Scan step source; external edges assume a slow outside clock so none is missed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (ctrl[`CTRL_EXT_CLK]) begin
         div_cnt <= 16'h0000;
         tick <= misc_sync[2] && !osc_prev; // RL1 RL11
      end else if (div_cnt + 16'h0001 >= scan_div) begin
         div_cnt <= 16'h0000;
         tick <= 1'b1; // RL1
      end else begin
         div_cnt <= div_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // Scan, debounce and hold sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SCAN;
         col <= 2'h0;
         cand <= '0;
         deb_cnt <= 8'h00;
      end else if (tick) begin
         case (state)
            SCAN: begin
               if (single_row) begin
                  cand <= '{row: first_row, col: col}; // RL10
                  deb_cnt <= 8'h01;
                  state <= misc_sync[1] ? DEBOUNCE : HOLD; // RL3
               end else begin
                  col <= col + 2'h1; // RL13
               end
            end
            DEBOUNCE: begin
               if (accept) begin
                  state <= HOLD;
               end else if (cand_closed) begin
                  deb_cnt <= deb_cnt + 8'h01; // RL3
               end else begin
                  state <= SCAN; // Bounce or phantom: resume scanning
                  col <= col + 2'h1;
               end
            end
            HOLD: begin
               if (!pressed[cand.row]) begin
                  state <= SCAN; // RL6
                  col <= col + 2'h1;
               end
            end
            default: state <= SCAN;
         endcase
      end
   end

   // Column drive, active low, one at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {column_drive_3, column_drive_2, column_drive_1, column_drive_0} <= 4'hf;
      end else begin
         {column_drive_3, column_drive_2, column_drive_1, column_drive_0} <= ~(4'h1 << col); // RL13
      end
   end

   // Last key register and key-valid flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_out <= 5'h00;
         key_valid <= 1'b0;
      end else if (accept) begin
         code_out <= (state == SCAN) ? {first_row, col} : cand; // RL7 RL10
         key_valid <= 1'b1; // RL4
      end else if (released) begin
         key_valid <= 1'b0; // RL5
      end
   end

   // Bus drivers enabled by the active-low enable pin; key-valid is never floated
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_oe <= 1'b0;
      end else begin
         code_oe <= !misc_sync[0]; // RL8 RL12
      end
   end

   // Write channel: address and data taken in either order, one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         ctrl <= `CTRL_RESET;
         scan_div <= SCAN_DIV_DEFAULT;
         deb_ticks <= `DEB_TICKS_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (aw_addr)
               `REG_CTRL: begin
                  if (w_strb[0]) ctrl <= w_data[1:0];
               end
               `REG_SCAN_DIV: begin
                  if (w_strb[0]) scan_div[7:0] <= w_data[7:0];
                  if (w_strb[1]) scan_div[15:8] <= w_data[15:8];
               end
               `REG_DEBOUNCE: begin
                  if (w_strb[0]) deb_ticks <= w_data[7:0];
               end
               `REG_STATUS: ; // Read-only, write ignored
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end
      end
   end

   // Ready only while nothing of that kind is held, so one write at most
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
               `REG_CTRL: s_axi_rdata[1:0] <= ctrl;
               `REG_SCAN_DIV: s_axi_rdata[15:0] <= scan_div;
               `REG_DEBOUNCE: s_axi_rdata[7:0] <= deb_ticks;
               `REG_STATUS: begin
                  s_axi_rdata[`ST_VALID] <= key_valid;
                  s_axi_rdata[`ST_CODE_HI:`ST_CODE_LO] <= code_out;
                  s_axi_rdata[`ST_STATE_HI:`ST_STATE_LO] <= state;
               end
               default: s_axi_rresp <= `RESP_SLVERR;
            endcase
         end
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence held_key_opens;
      state == HOLD && tick && !pressed[cand.row];
   endsequence

   sequence back_to_scan;
      state == SCAN && !key_valid;
   endsequence

   a_tick_source: assert property (tick && ctrl[`CTRL_EXT_CLK] && $past(ctrl[`CTRL_EXT_CLK]) // RL1
      |-> $past(misc_sync[2] && !osc_prev)) else $error("scan step without clock edge");
   a_ghost_reject: assert property (state == SCAN && tick && !single_row |=> state == SCAN) // RL2
      else $error("ambiguous column left scan");
   a_debounce_bypass: assert property (state == SCAN && tick && single_row && !misc_sync[1] // RL3
      |=> key_valid && state == HOLD) else $error("bypass did not accept at once");
   a_valid_rise: assert property ($rose(key_valid) |-> $past(accept)) // RL4
      else $error("key valid rose without acceptance");
   a_valid_release: assert property (held_key_opens |=> back_to_scan) // RL5 RL6
      else $error("key valid stayed high after release");
   a_code_hold: assert property (!accept |=> $stable(code_out)) // RL7
      else $error("code changed without new key");
   // Range judged at acceptance only: the held code may outlive a later switch to 16 keys
   a_code_range: assert property (accept |=> code_out <= 5'd19 && ($past(ctrl[`CTRL_ROWS5]) || code_out <= 5'd15)) // RL9 RL10
      else $error("code outside key range");
   a_enable_path: assert property (misc_sync[0] |=> !code_oe) // RL8 RL12
      else $error("code driven while enable high");
   a_col_onehot: assert property ($onehot(~{column_drive_3, column_drive_2, column_drive_1, column_drive_0}) || $past(!aresetn)) // RL13
      else $error("not exactly one column active");
   // Leaving debounce or hold for scan steps the column, so only a busy-to-busy cycle must keep it
   a_col_frozen: assert property (state != SCAN ##1 state != SCAN |-> $stable(col)) // RL13
      else $error("scan advanced while key busy");

endmodule
`default_nettype wire

// file: verilog/key_scan_pkg.sv
// Types shared by the key scan encoder
`default_nettype none
package key_scan_pkg;

   // Key position: code index is row * 4 + column
   typedef struct packed {
      logic [2:0] row;
      logic [1:0] col;
   } key_pos_t;

   typedef enum logic [1:0] {
      SCAN = 2'b00,
      DEBOUNCE = 2'b01,
      HOLD = 2'b10
   } scan_state_t;

endpackage
`default_nettype wire

// file: verilog/key_scan_regs.svh
// Register map, field positions, reset values and timing constants of the key scan encoder
`ifndef KEY_SCAN_REGS_SVH
`define KEY_SCAN_REGS_SVH

`define REG_CTRL 4'h0
`define REG_SCAN_DIV 4'h4
`define REG_DEBOUNCE 4'h8
`define REG_STATUS 4'hc

`define CTRL_EXT_CLK 0
`define CTRL_ROWS5 1
`define CTRL_RESET 2'h2

`define DEB_TICKS_RESET 8'h04
`define CLK_PERIOD_NS 10
`define SCAN_PERIOD_NS 100000

`define ST_VALID 0
`define ST_CODE_LO 1
`define ST_CODE_HI 5
`define ST_STATE_LO 8
`define ST_STATE_HI 9

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
